// ==== verilog/wbsc_pkg.sv ====
package wbsc_pkg;

  // Counter geometry
  localparam int LEVEL_W = 6;
  localparam logic [5:0] LEVEL_MIN = 6'h00;
  localparam logic [5:0] LEVEL_MAX = 6'h3f;
  localparam logic [5:0] LEVEL_RST = 6'h20;

  // Control voltage scale, millivolts
  localparam logic [11:0] DAC_BASE_MV = 12'h5dc;
  localparam logic [11:0] DAC_STEP_MV = 12'h01e;

  // Line timing
  localparam int LINE_W = 10;
  localparam logic [9:0] LINE_MAX = 10'h3ff;
  localparam logic [9:0] STEP_LINE = 10'h014;
  localparam logic [9:0] LINES_SPLIT = 10'h120;
  localparam logic [9:0] LINES_RST = 10'h106;

  // Register offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_LEVELS = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_VOLTS = 8'h14;

  // Control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_ABORT_BIT = 2;
  localparam logic CTRL_AUTO_RST = 1'b1;

  // Status fields
  localparam int EVT_W = 3;
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_CANCEL_BIT = 1;
  localparam int EVT_SAT_BIT = 2;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADJ = 3'b010,
    ST_DONE = 3'b100
  } wbsc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wbsc_req_t;

  typedef struct packed {
    logic [5:0] level;
    logic busy;
    logic sat;
  } wbsc_chan_t;

  typedef struct packed {
    logic step;
    logic vd_rise;
    logic ccir;
    logic [9:0] lines;
    logic [9:0] line_cnt;
  } wbsc_time_t;

  function automatic logic [5:0] wbsc_sat_step(input logic [5:0] lvl, input logic up);
    if (up)
      return (lvl == LEVEL_MAX) ? lvl : 6'(lvl + 6'h01);
    else
      return (lvl == LEVEL_MIN) ? lvl : 6'(lvl - 6'h01);
  endfunction : wbsc_sat_step

  function automatic logic [11:0] wbsc_level_mv(input logic [5:0] lvl);
    return 12'(DAC_BASE_MV + 12'(lvl) * DAC_STEP_MV);
  endfunction : wbsc_level_mv

endpackage : wbsc_pkg

// ==== verilog/wbsc_line_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module wbsc_line_timer
  import wbsc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Drive pulses
  input wire logic vd_i,
  input wire logic hd_i,
  // Timing out
  output wbsc_time_t time_o
);

  logic vd_q_reg;
  logic hd_q_reg;
  logic [9:0] line_cnt_reg;
  logic [9:0] lines_reg;
  logic step_reg;
  logic vd_rise_reg;
  logic vd_rise;
  logic hd_rise;

  assign vd_rise = vd_i & ~vd_q_reg;
  assign hd_rise = hd_i & ~hd_q_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      vd_q_reg <= 1'b0;
      hd_q_reg <= 1'b0;
    end
    else
    begin
      vd_q_reg <= vd_i;
      hd_q_reg <= hd_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      line_cnt_reg <= 10'h000;
    else if (vd_rise)
      line_cnt_reg <= 10'h000;
    else if (hd_rise && line_cnt_reg != LINE_MAX)
      line_cnt_reg <= 10'(line_cnt_reg + 10'h001);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      lines_reg <= LINES_RST;
    else if (vd_rise)
      lines_reg <= line_cnt_reg;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      step_reg <= 1'b0;
      vd_rise_reg <= 1'b0;
    end
    else
    begin
      step_reg <= hd_rise && !vd_rise && (line_cnt_reg == 10'(STEP_LINE - 10'h001));
      vd_rise_reg <= vd_rise;
    end
  end

  assign time_o.step = step_reg;
  assign time_o.vd_rise = vd_rise_reg;
  assign time_o.ccir = (lines_reg > LINES_SPLIT);
  assign time_o.lines = lines_reg;
  assign time_o.line_cnt = line_cnt_reg;

endmodule : wbsc_line_timer
`default_nettype wire

// ==== verilog/wbsc_step_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
module wbsc_step_chan
  import wbsc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic arm_i,
  input wire logic abort_i,
  input wire logic step_i,
  input wire logic dir_up_i,
  // Channel state
  output wbsc_chan_t chan_o
);

  logic [5:0] level_reg;
  logic busy_reg;
  logic ref_valid_reg;
  logic ref_dir_reg;
  logic sat_reg;
  logic go_step;
  logic reversed;

  assign reversed = ref_valid_reg && (dir_up_i != ref_dir_reg);
  assign go_step = step_i && busy_reg && !reversed;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      level_reg <= LEVEL_RST;
    else if (go_step)
      level_reg <= wbsc_sat_step(level_reg, dir_up_i);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      busy_reg <= 1'b0;
    else if (arm_i)
      busy_reg <= 1'b1;
    else if (abort_i || (step_i && busy_reg && reversed))
      busy_reg <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      ref_valid_reg <= 1'b0;
      ref_dir_reg <= 1'b0;
    end
    else if (arm_i)
      ref_valid_reg <= 1'b0;
    else if (step_i && busy_reg && !ref_valid_reg)
    begin
      ref_valid_reg <= 1'b1;
      ref_dir_reg <= dir_up_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      sat_reg <= 1'b0;
    else
      sat_reg <= go_step && (dir_up_i ? (level_reg == LEVEL_MAX) : (level_reg == LEVEL_MIN));
  end

  assign chan_o.level = level_reg;
  assign chan_o.busy = busy_reg;
  assign chan_o.sat = sat_reg;

endmodule : wbsc_step_chan
`default_nettype wire

// ==== verilog/wbsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Each channel holds a 6-bit counter stepping up or down by its direction.
// - Two independent channels: red against green, blue against green.
// - Adjustment begins on a start rising edge (auto start on) or a register start; counters frozen otherwise.
// - One step per vertical period until the direction input reverses.
// - Counter value at reversal is kept as the balance result.
// - Code maps to control voltage 1.5V to 3.39V, about 30mV per step.
// - Active-low completion indicator goes low when adjustment finishes.
// - Line count preset by vertical drive; line standard chosen automatically.
module wbsc_top
  import wbsc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Drive pulses
  input wire logic vd_i,
  input wire logic hd_i,
  // Trigger and inhibit
  input wire logic start_i,
  input wire logic low_light_i,
  // Comparator results, high when green is larger
  input wire logic red_dir_i,
  input wire logic blue_dir_i,
  // Register port
  input wire wbsc_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  // Converter codes and indicators
  output logic [5:0] red_level_o,
  output logic [5:0] blue_level_o,
  output logic done_n_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  wbsc_time_t tim;
  wbsc_chan_t red_chan;
  wbsc_chan_t blue_chan;
  wbsc_state_t state_reg;
  wbsc_state_t state_next;
  logic start_q_reg;
  logic auto_en_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [2:0] evt;
  logic [31:0] rdata_reg;
  logic done_n_reg;
  logic irq_reg;
  logic sw_start;
  logic sw_abort;
  logic trig;
  logic go;
  logic abort;
  logic wr_ctrl;

  assign wr_ctrl = reg_req_i.wr && (reg_req_i.addr == OFS_CTRL);
  assign sw_start = wr_ctrl && reg_req_i.wdata[CTRL_START_BIT];
  assign sw_abort = wr_ctrl && reg_req_i.wdata[CTRL_ABORT_BIT];

  assign trig = (auto_en_reg && start_i && !start_q_reg) || sw_start;
  assign go = trig && !low_light_i && (state_reg != ST_ADJ);
  assign abort = sw_abort && (state_reg == ST_ADJ);

  ////////////////////////////////////////////////////////////////////////////
  wbsc_line_timer u_timer (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .vd_i(vd_i),
    .hd_i(hd_i),
    .time_o(tim)
  );

  wbsc_step_chan u_red (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .arm_i(go),
    .abort_i(abort),
    .step_i(tim.step),
    .dir_up_i(red_dir_i),
    .chan_o(red_chan)
  );

  wbsc_step_chan u_blue (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .arm_i(go),
    .abort_i(abort),
    .step_i(tim.step),
    .dir_up_i(blue_dir_i),
    .chan_o(blue_chan)
  );

  assign red_level_o = red_chan.level;
  assign blue_level_o = blue_chan.level;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (go)
          state_next = ST_ADJ;
      ST_ADJ:
        if (abort)
          state_next = ST_IDLE;
        else if (!red_chan.busy && !blue_chan.busy)
          state_next = ST_DONE;
      ST_DONE:
        if (go)
          state_next = ST_ADJ;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      start_q_reg <= 1'b0;
    else
      start_q_reg <= start_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      done_n_reg <= 1'b1;
    else
      done_n_reg <= (state_next != ST_DONE);
  end

  assign done_n_o = done_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      auto_en_reg <= CTRL_AUTO_RST;
    else if (wr_ctrl)
      auto_en_reg <= reg_req_i.wdata[CTRL_AUTO_BIT];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      mask_reg <= MASK_RST;
    else if (reg_req_i.wr && reg_req_i.addr == OFS_MASK)
      mask_reg <= reg_req_i.wdata[EVT_W-1:0];
  end

  always_comb
  begin
    evt = 3'h0;
    evt[EVT_DONE_BIT] = (state_reg == ST_ADJ) && (state_next == ST_DONE);
    evt[EVT_CANCEL_BIT] = trig && low_light_i;
    evt[EVT_SAT_BIT] = red_chan.sat || blue_chan.sat;
    status_next = status_reg;
    if (reg_req_i.wr && reg_req_i.addr == OFS_STATUS)
      status_next = status_reg & ~reg_req_i.wdata[EVT_W-1:0];
    // Set beats a same-cycle clear
    status_next = status_next | evt;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      status_reg <= EVT_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign irq_o = irq_reg;

  // Register readback, codes also given as millivolts; unmapped reads give zero
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      rdata_reg <= 32'h0000_0000;
    else if (!reg_req_i.rd)
      rdata_reg <= 32'h0000_0000;
    else
    begin
      unique case (reg_req_i.addr)
        OFS_CTRL:
          rdata_reg <= {30'h0, auto_en_reg, 1'b0};
        OFS_STATUS:
          rdata_reg <= {29'h0, status_reg};
        OFS_MASK:
          rdata_reg <= {29'h0, mask_reg};
        OFS_LEVELS:
          rdata_reg <= {18'h0, blue_chan.level, 2'h0, red_chan.level};
        OFS_STATE:
          rdata_reg <= {6'h0, tim.lines, 8'h0, 1'b0, tim.ccir, blue_chan.busy,
                        red_chan.busy, 1'b0, state_reg};
        OFS_VOLTS:
          rdata_reg <= {4'h0, wbsc_level_mv(blue_chan.level), 4'h0,
                        wbsc_level_mv(red_chan.level)};
        default:
          rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_IDLE_FROZEN: assert property (
    (state_reg != ST_ADJ) && !go |=> $stable(red_level_o) && $stable(blue_level_o))
    else $error("Level moved outside adjustment");

  AST_STEP_ONLY_ON_TICK: assert property (
    $changed(red_level_o) |-> $past(tim.step) && $past(state_reg) == ST_ADJ)
    else $error("Red level moved without a field step");

  AST_ONE_STEP: assert property (
    $changed(blue_level_o) |->
      (blue_level_o == 6'($past(blue_level_o) + 6'h01)) ||
      (blue_level_o == 6'($past(blue_level_o) - 6'h01)))
    else $error("Blue level moved by more than one step");

  AST_DIR_UP: assert property (
    (red_level_o > $past(red_level_o)) |-> $past(red_dir_i))
    else $error("Red rose while direction was low");

  AST_NO_WRAP: assert property (
    $past(red_level_o) == LEVEL_MAX && red_level_o != LEVEL_MAX |-> red_level_o == 6'h3e)
    else $error("Red level wrapped");

  AST_DONE_LOW: assert property (
    state_reg == ST_DONE |-> !done_n_o)
    else $error("Indicator high while done");

  AST_RESULT_HELD: assert property (
    state_reg == ST_DONE && !go |=> $stable(red_level_o) && state_reg == ST_DONE)
    else $error("Result not held");

  AST_VD_PRESET: assert property (
    $rose(vd_i) |=> tim.line_cnt == 10'h000)
    else $error("Line count not preset");

  AST_INHIBIT_BLOCKS: assert property (
    state_reg == ST_IDLE && low_light_i |=> state_reg == ST_IDLE)
    else $error("Started under low light");

  AST_IRQ_LEVEL: assert property (
    ##1 irq_o == |($past(status_next) & $past(mask_reg)))
    else $error("Interrupt output mismatch");

  COV_DONE: cover property (state_reg == ST_ADJ ##1 state_reg == ST_DONE);
  COV_SAT: cover property (red_chan.sat);
  COV_CCIR: cover property (tim.ccir && tim.vd_rise);
  COV_CANCEL: cover property (status_reg[EVT_CANCEL_BIT]);

endmodule : wbsc_top
`default_nettype wire

// ==== dv/wbsc_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module wbsc_analog_model
  import wbsc_pkg::*;
#(
  parameter int LINE_CYC = 8,
  parameter int FIELD_LINES = 40
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Scene and trigger
  input wire logic trig_i,
  input wire logic [6:0] video_pct_i,
  input wire logic [6:0] red_tgt_i,
  input wire logic [6:0] blue_tgt_i,
  // Converter codes fed back
  input wire logic [5:0] red_level_i,
  input wire logic [5:0] blue_level_i,
  // Towards the block
  output logic vd_o,
  output logic hd_o,
  output logic start_o,
  output logic low_light_o,
  output logic red_dir_o,
  output logic blue_dir_o
);
  int cyc;
  int line;
  logic line_colour_select;
  ////////////////////////////////////////////////////////////////
  // Drive pulse timing
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      cyc <= 0;
      line <= 0;
    end
    else if (cyc == LINE_CYC - 1)
    begin
      cyc <= 0;
      line <= (line == FIELD_LINES - 1) ? 0 : line + 1;
    end
    else
      cyc <= cyc + 1;
  end
  assign hd_o = (cyc < 2);
  assign vd_o = (line == 0);
  assign line_colour_select = line[0];
  ////////////////////////////////////////////////////////////////
  // Comparators; hold refreshed right after vd so each field compares anew
  // Green above sets high
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      red_dir_o <= 1'b0;
      blue_dir_o <= 1'b0;
    end
    else if (cyc == 0 && line == 1 && line_colour_select)
      blue_dir_o <= ({1'b0, blue_level_i} < blue_tgt_i);
    else if (cyc == 0 && line == 2 && !line_colour_select)
      red_dir_o <= ({1'b0, red_level_i} < red_tgt_i);
  end
  ////////////////////////////////////////////////////////////////
  // Low light below 30 percent
  assign low_light_o = (video_pct_i < 7'h1e);
  assign start_o = trig_i & ~low_light_o;
endmodule : wbsc_analog_model
`default_nettype wire

// ==== dv/white_balance_step_counter_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module white_balance_step_counter_test;
  import wbsc_pkg::*;
  localparam int FIELD = 320;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic trig = 1'b0;
  logic [6:0] video_pct = 7'h32;
  logic [6:0] red_tgt = 7'h25;
  logic [6:0] blue_tgt = 7'h1c;
  wbsc_req_t req = '0;
  logic [31:0] rdata;
  logic [5:0] red_lvl;
  logic [5:0] blue_lvl;
  logic done_n, irq, vd, hd, start, ll, rdir, bdir, vd_q;
  logic [5:0] lv [2];
  logic [5:0] pv [2];
  int nc [2];
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] v;
  always #25 clk = ~clk;
  wbsc_top i_dut (.core_clk_i(clk), .resetn_i(rstn), .vd_i(vd), .hd_i(hd), .start_i(start),
    .low_light_i(ll), .red_dir_i(rdir), .blue_dir_i(bdir), .reg_req_i(req),
    .reg_rdata_o(rdata), .red_level_o(red_lvl), .blue_level_o(blue_lvl),
    .done_n_o(done_n), .irq_o(irq));
  wbsc_analog_model i_far (.core_clk_i(clk), .resetn_i(rstn), .trig_i(trig),
    .video_pct_i(video_pct), .red_tgt_i(red_tgt), .blue_tgt_i(blue_tgt),
    .red_level_i(red_lvl), .blue_level_i(blue_lvl), .vd_o(vd), .hd_o(hd), .start_o(start),
    .low_light_o(ll), .red_dir_o(rdir), .blue_dir_o(bdir));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic pulse_trig();
    @(posedge clk);
    trig <= 1'b1;
    repeat (3) @(posedge clk);
    trig <= 1'b0;
  endtask : pulse_trig
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////
  // Step monitor: at most one step per field, size one modulo 64, so a wrap passes
  always_comb
  begin
    lv[0] = red_lvl;
    lv[1] = blue_lvl;
  end
  always @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (vd && !vd_q)
        nc[i] = 0;
      if (rstn && lv[i] !== pv[i])
      begin
        nc[i]++;
        check(32'(nc[i]), 32'h1);
        check({31'h0, 6'(lv[i] - pv[i]) == 6'h01 || 6'(pv[i] - lv[i]) == 6'h01}, 32'h1);
      end
      pv[i] = lv[i];
    end
    vd_q = vd;
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(OFS_CTRL, v);
    check(v, 32'h2);
    reg_rd(OFS_LEVELS, v);
    check(v, 32'h2020);
    reg_rd(OFS_VOLTS, v);
    check(v, 32'h099c_099c);
    reg_rd(8'h18, v);
    check(v, 32'h0);
    reg_rd(OFS_STATUS, v);
    check(v, 32'h0);
    check({30'h0, done_n, irq}, 32'h2);
    $display("test reset done");
    // Scene wants change, but no start given
    repeat (2 * FIELD) @(posedge clk);
    reg_rd(OFS_LEVELS, v);
    check(v, 32'h2020);
    // Preset by vd, so the hd pulse beside vd is not counted
    reg_rd(OFS_STATE, v);
    check(v & 32'h03ff_0047, 32'h0027_0001);
    $display("test idle done");
    // Low light: trigger cancelled, register start refused; auto start kept on
    video_pct <= 7'h0a;
    pulse_trig();
    reg_wr(OFS_CTRL, 32'h3);
    repeat (2 * FIELD) @(posedge clk);
    reg_rd(OFS_STATUS, v);
    check(v, 32'h2);
    reg_rd(OFS_LEVELS, v);
    check(v, 32'h2020);
    // Mask lands one edge before irq follows it
    reg_wr(OFS_MASK, 32'h2);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h1);
    reg_wr(OFS_STATUS, 32'h2);
    @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    $display("test low light done");
    // Adjustment: red climbs to target, blue falls past it
    video_pct <= 7'h32;
    reg_wr(OFS_MASK, 32'h1);
    pulse_trig();
    reg_rd(OFS_STATE, v);
    check(v & 32'h7, 32'h2);
    for (int k = 0; k < 20 * FIELD && done_n !== 1'b0; k++)
      @(posedge clk);
    check({red_lvl, 2'h0, blue_lvl}, {6'h25, 2'h0, 6'h1b});
    reg_rd(OFS_STATE, v);
    check(v & 32'h37, 32'h4);
    reg_rd(OFS_VOLTS, v);
    check(v, 32'h0906_0a32);
    check({31'h0, irq}, 32'h1);
    repeat (2 * FIELD) @(posedge clk);
    reg_rd(OFS_LEVELS, v);
    check(v, 32'h1b25);
    check({31'h0, done_n}, 32'h0);
    $display("test adjust done");
    // Both ends: red pinned at top, blue at bottom
    reg_wr(OFS_STATUS, 32'h7);
    reg_wr(OFS_MASK, 32'h4);
    red_tgt <= 7'h40;
    blue_tgt <= 7'h00;
    // Stale directions would record a reversed first step
    repeat (FIELD) @(posedge clk);
    pulse_trig();
    for (int k = 0; k < 45 * FIELD && !(red_lvl === 6'h3f && blue_lvl === 6'h00); k++)
      @(posedge clk);
    repeat (2 * FIELD) @(posedge clk);
    check({red_lvl, 2'h0, blue_lvl}, {6'h3f, 2'h0, 6'h00});
    reg_rd(OFS_STATUS, v);
    check(v & 32'h4, 32'h4);
    check({30'h0, done_n, irq}, 32'h3);
    reg_wr(OFS_CTRL, 32'h4);
    reg_rd(OFS_STATE, v);
    check(v & 32'h2, 32'h0);
    $display("test saturate done");
    give_verdict();
  end
endmodule : white_balance_step_counter_test
`default_nettype wire
